// *** src/card_pkg.sv ***
// Constants, carrier structs and state types for the processor card glue
package card_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TS_PERIOD_NS  = 320;
  localparam int unsigned TS_HALF_CYC   = TS_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned TS_CNT_W      = 5;
  localparam int unsigned RST_HOLD_MS   = 50;
  // Hold no longer than RST_HOLD_MS, since the division rounds down
  localparam int unsigned RST_HOLD_CYC  = RST_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W     = 24;

  localparam logic [15:0] LOW_BASE      = 16'h0000;
  localparam logic [15:0] HIGH_BASE     = 16'hc000;
  localparam logic [15:0] EPROM_END     = 16'h2000;
  localparam logic [15:0] RAM_END       = 16'h3000;
  localparam int unsigned EPROM_N       = 4;
  localparam int unsigned RAM_N         = 8;
  localparam int unsigned EPROM_IDX_LSB = 11;
  localparam int unsigned EPROM_IDX_W   = 2;
  localparam int unsigned RAM_IDX_LSB   = 9;
  localparam int unsigned RAM_IDX_W     = 3;

  typedef enum logic [1:0] {
    RST_HOLD = 2'h0,
    RST_ARM  = 2'h1,
    RST_RUN  = 2'h3
  } rst_state_e;

  typedef struct packed {
    logic irq_high_n;
    logic irq_mid_n;
    logic irq_low_n;
    logic serial_in_line_n;
  } aux_in_s;

  typedef struct packed {
    logic             pb_n;
    logic             ext_clk;
    logic             ext_sel;
    logic             mem_off;
    logic             reloc;
    logic [1:0]       exp_cut;
    aux_in_s          aux;
  } pin_in_s;

  typedef struct packed {
    logic [EPROM_N-1:0] eprom;
    logic [RAM_N-1:0]   ram;
  } mem_sel_s;

  typedef struct packed {
    rst_state_e           rst_st;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic                 sys_rst_n;
    logic                 ext_q;
    logic [TS_CNT_W-1:0]  ts_cnt;
    logic                 ts_clk;
    mem_sel_s             sel;
    logic                 bus_oe;
    logic                 data_oe;
    logic [1:0]           exp_oe;
    logic [1:0]           exp_out;
    aux_in_s              aux;
    logic                 sod_n;
  } card_state_s;

  localparam aux_in_s AUX_IDLE = 4'hf;
  localparam pin_in_s PIN_RST  = '{pb_n: 1'b1, aux: AUX_IDLE, default: '0};
  localparam card_state_s STATE_RST = '{rst_st: RST_HOLD, aux: AUX_IDLE,
                                        sod_n: 1'b1, default: '0};
endpackage

// *** src/pin_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** src/cpu_card_ctrl.sv ***
// Processor card glue: time states, reset one-shot, memory decode, bus release
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Crystal mode gives a 320 ns time state from the system clock.
// - External clock of 1-6 MHz; card runs at half its frequency.
// - Power-on or pushbutton fires a one-shot holding system reset low.
// - Four EPROM selects decode 0000-1FFF, 2K each, by default.
// - Eight RAM selects decode 2000-2FFF, 512 bytes each, by default.
// - Disable strap turns off all on-card memory selects.
// - Relocate strap moves the 12K window to C000-EFFF, same layout.
// - Bus buffers are released so another master can take the bus.
// - Expansion lines are held low unless their straps are cut.
// - Aux interrupts and serial in/out lines pass via the aux socket.
module cpu_card_ctrl
  import card_pkg::*;
#(
  parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        pb_reset_n_i,
  input  wire logic        ext_clk_i,
  input  wire logic        ext_clk_sel_i,
  input  wire logic        mem_off_i,
  input  wire logic        reloc_i,
  input  wire logic [1:0]  exp_cut_i,
  input  wire logic        aux_irq_high_n_i,
  input  wire logic        aux_irq_mid_n_i,
  input  wire logic        aux_irq_low_n_i,
  input  wire logic        serial_in_line_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        mem_req_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        bus_grant_i,
  input  wire logic        serial_out_i,
  output logic             time_state_clk_o,
  output logic             sys_reset_n_o,
  output mem_sel_s         mem_sel_o,
  output logic             bus_oe_o,
  output logic             bus_data_oe_o,
  output logic [1:0]       exp_out_o,
  output logic [1:0]       exp_oe_o,
  output aux_in_s          aux_o,
  output logic             serial_out_line_n_o
);
  card_state_s q, d;
  pin_in_s     pin_raw, pin_s;
  logic [15:0] base, off;
  logic        access;

  assign pin_raw = '{pb_n: pb_reset_n_i, ext_clk: ext_clk_i,
                     ext_sel: ext_clk_sel_i, mem_off: mem_off_i,
                     reloc: reloc_i, exp_cut: exp_cut_i,
                     aux: '{aux_irq_high_n_i, aux_irq_mid_n_i,
                            aux_irq_low_n_i, serial_in_line_n_i}};

  pin_sync #(
    .W       ($bits(pin_in_s)),
    .RST_VAL (PIN_RST)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (pin_raw),
    .sync_o    (pin_s)
  );

  assign base   = pin_s.reloc ? HIGH_BASE : LOW_BASE;
  assign off    = addr_i - base;
  // Window wraps below the base, so addresses under C000 miss when moved
  assign access = !mem_req_n_i && !pin_s.mem_off && !bus_grant_i;

  always_comb begin
    d = q;
    // Reset one-shot; a held button does not retrigger until released
    unique case (q.rst_st)
      RST_HOLD: begin
        d.sys_rst_n = 1'b0;
        d.rst_cnt   = q.rst_cnt + 1'b1;
        if (q.rst_cnt == RST_CNT_W'(RST_HOLD_CYCLES - 1)) begin
          d.rst_st    = RST_ARM;
          d.rst_cnt   = '0;
          d.sys_rst_n = 1'b1;
        end
      end
      RST_ARM: begin
        if (pin_s.pb_n) begin
          d.rst_st = RST_RUN;
        end
      end
      RST_RUN: begin
        if (!pin_s.pb_n) begin
          d.rst_st    = RST_HOLD;
          d.sys_rst_n = 1'b0;
        end
      end
      default: begin
        d.rst_st    = RST_HOLD;
        d.rst_cnt   = '0;
        d.sys_rst_n = 1'b0;
      end
    endcase

    // Time states keep running through system reset
    d.ext_q = pin_s.ext_clk;
    if (pin_s.ext_sel) begin
      d.ts_cnt = '0;
      if (pin_s.ext_clk && !q.ext_q) begin
        d.ts_clk = ~q.ts_clk;
      end
    end else if (q.ts_cnt == TS_CNT_W'(TS_HALF_CYC - 1)) begin
      d.ts_cnt = '0;
      d.ts_clk = ~q.ts_clk;
    end else begin
      d.ts_cnt = q.ts_cnt + 1'b1;
    end

    d.sel = '0;
    if (access && off < EPROM_END) begin
      d.sel.eprom = EPROM_N'(1) << off[EPROM_IDX_LSB +: EPROM_IDX_W];
    end else if (access && off < RAM_END) begin
      d.sel.ram = RAM_N'(1) << off[RAM_IDX_LSB +: RAM_IDX_W];
    end

    d.bus_oe  = !bus_grant_i;
    d.data_oe = !bus_grant_i && !wr_n_i;
    d.exp_oe  = ~pin_s.exp_cut;
    d.aux     = pin_s.aux;
    d.sod_n   = serial_out_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign time_state_clk_o    = q.ts_clk;
  assign sys_reset_n_o       = q.sys_rst_n;
  assign mem_sel_o           = q.sel;
  assign bus_oe_o            = q.bus_oe;
  assign bus_data_oe_o       = q.data_oe;
  assign exp_out_o           = q.exp_out;
  assign exp_oe_o            = q.exp_oe;
  assign aux_o               = q.aux;
  assign serial_out_line_n_o = q.sod_n;

  localparam int HALF_M1 = TS_HALF_CYC - 1;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_ts_toggle: assert property (
    !pin_s.ext_sel && q.ts_cnt == TS_CNT_W'(HALF_M1)
    |=> $changed(q.ts_clk) && q.ts_cnt == '0)
    else $error("time state did not toggle at half period");

  chk_ts_hold: assert property (
    !pin_s.ext_sel && q.ts_cnt != TS_CNT_W'(HALF_M1)
    |=> $stable(q.ts_clk))
    else $error("time state toggled early");

  chk_ext_half: assert property (
    pin_s.ext_sel && pin_s.ext_clk && !q.ext_q |=> $changed(q.ts_clk))
    else $error("external clock edge not halved");

  chk_rst_len: assert property (
    $rose(q.sys_rst_n)
    |-> $past(q.rst_cnt) == RST_CNT_W'(RST_HOLD_CYCLES - 1))
    else $error("system reset released at wrong count");

  chk_pb_fire: assert property (
    q.rst_st == RST_RUN && !pin_s.pb_n |=> !q.sys_rst_n [*2])
    else $error("pushbutton did not assert system reset");

  chk_eprom_map: assert property (
    access && off < EPROM_END
    |=> q.sel.eprom == EPROM_N'(1) << $past(off[12:11]) && q.sel.ram == '0)
    else $error("eprom select wrong");

  chk_ram_map: assert property (
    access && off >= EPROM_END && off < RAM_END
    |=> q.sel.ram == RAM_N'(1) << $past(off[11:9]) && q.sel.eprom == '0)
    else $error("ram select wrong");

  chk_mem_off: assert property (
    pin_s.mem_off |=> q.sel == '0)
    else $error("select while on-card memory disabled");

  chk_reloc_miss: assert property (
    pin_s.reloc && (addr_i < HIGH_BASE || addr_i >= HIGH_BASE + RAM_END)
    |=> q.sel == '0)
    else $error("relocated window decoded outside C000-EFFF");

  chk_release: assert property (
    bus_grant_i |=> !q.bus_oe && !q.data_oe && q.sel == '0)
    else $error("bus driven while released");

  chk_exp_low: assert property (
    !rst_i |=> q.exp_oe == ~$past(pin_s.exp_cut) && q.exp_out == '0)
    else $error("expansion line strap not followed");

  chk_aux_pass: assert property (
    !rst_i |=> q.aux == $past(pin_s.aux) && q.sod_n == $past(serial_out_i))
    else $error("aux socket line not passed");

  cov_reloc_hit: cover property (pin_s.reloc && access && off < EPROM_END);
  cov_ext_mode:  cover property (pin_s.ext_sel ##1 $changed(q.ts_clk));
  cov_pb_reset:  cover property (q.rst_st == RST_RUN ##1 !q.sys_rst_n);
  cov_release:   cover property (!bus_grant_i ##1 bus_grant_i);
endmodule
`default_nettype wire

// *** bench/ext_mem_card.sv ***
// Backplane memory card that keeps clear of the on-card window
`timescale 1ns/1ps
`default_nettype none
module ext_mem_card #(
  parameter int unsigned LAT = 1
) (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        mem_req_n_i,
  input  wire logic        reloc_i,
  input  wire logic        mem_off_i,
  output logic             hit_o
);
  logic [LAT:0] pipe_q;
  logic         hit_d;
  // Low 16K, or C000-FFFF when relocated, left to the processor card
  assign hit_d = !mem_req_n_i && (mem_off_i ||
                 (reloc_i ? addr_i < 16'hc000 : addr_i >= 16'h4000));
  // LAT above 1 models a slow card
  always_ff @(posedge clk_sys_i) pipe_q <= {pipe_q[LAT-1:0], hit_d};
  assign hit_o = pipe_q[LAT-1];
endmodule
`default_nettype wire

// *** bench/tb_cpu_card_ctrl.sv ***
// Self-checking bench for the processor card glue
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_card_ctrl;
  import card_pkg::*;
  localparam int unsigned HOLD = 20;
  typedef struct packed {
    mem_sel_s sel;
    logic     oe;
    logic     doe;
  } note_s;
  logic        clk = 0, rst = 1, pb = 1, ext = 0, xsel = 0, off = 0;
  logic        rel = 0, req_n = 1, wr_n = 1, gnt = 0, so = 1, hit;
  logic [1:0]  cut = 0, xout, xoe;
  logic [3:0]  aux = 4'hf;
  logic [15:0] addr = 0;
  logic        tsc, srst_n, boe, bdoe, sol;
  mem_sel_s    msel;
  aux_in_s     auxo;
  int          err_total = 0, checks_done = 0, seed = 12, ec = 0, n;
  note_s       q[$];
  localparam logic [15:0] AD [15] = '{16'h0000, 16'h1800, 16'h1fff,
    16'h2000, 16'h2e00, 16'h2fff, 16'h3000, 16'hbfff, 16'hc000,
    16'hd800, 16'hdfff, 16'he000, 16'hefff, 16'hf000, 16'hffff};

  cpu_card_ctrl #(.RST_HOLD_CYCLES(HOLD)) uut (
    .clk_sys_i(clk), .rst_i(rst), .pb_reset_n_i(pb), .ext_clk_i(ext),
    .ext_clk_sel_i(xsel), .mem_off_i(off), .reloc_i(rel), .exp_cut_i(cut),
    .aux_irq_high_n_i(aux[3]), .aux_irq_mid_n_i(aux[2]),
    .aux_irq_low_n_i(aux[1]), .serial_in_line_n_i(aux[0]),
    .addr_i(addr), .mem_req_n_i(req_n), .wr_n_i(wr_n), .bus_grant_i(gnt),
    .serial_out_i(so), .time_state_clk_o(tsc), .sys_reset_n_o(srst_n),
    .mem_sel_o(msel), .bus_oe_o(boe), .bus_data_oe_o(bdoe),
    .exp_out_o(xout), .exp_oe_o(xoe), .aux_o(auxo),
    .serial_out_line_n_o(sol));
  ext_mem_card card (.clk_sys_i(clk), .addr_i(addr), .mem_req_n_i(req_n),
    .reloc_i(rel), .mem_off_i(off), .hit_o(hit));

  initial forever #2.5 clk = ~clk;
  // 4 MHz external clock at 40 percent duty, only in external mode
  always @(posedge clk) begin
    ec <= (ec == 49) ? 0 : ec + 1;
    ext <= xsel && ec < 20;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task lvl(input logic v, inout int k);
    while (tsc !== v && k < 500) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task per(output int k);
    k = 0;
    lvl(0, k);
    lvl(1, k);
    k = 0;
    lvl(0, k);
    lvl(1, k);
  endtask
  task hold_len(output int k);
    k = 0;
    while (srst_n !== 1 && k < 1000) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  function automatic note_s want(logic [15:0] a, logic w, logic g);
    logic [15:0] o;
    note_s       r;
    o = a - (rel ? HIGH_BASE : LOW_BASE);
    r = '0;
    r.oe = !g;
    r.doe = !g && !w;
    if (!off && !g) begin
      if (o < EPROM_END) r.sel.eprom[o[12:11]] = 1'b1;
      else if (o < RAM_END) r.sel.ram[o[11:9]] = 1'b1;
    end
    return r;
  endfunction
  task acc(input logic [15:0] a, input logic w, input logic g);
    @(posedge clk);
    addr <= a;
    req_n <= 1'b0;
    wr_n <= w;
    gnt <= g;
    q.push_back(want(a, w, g));
  endtask

  initial begin : mon
    note_s e;
    forever begin
      @(negedge clk);
      if (q.size() != 0) begin
        @(posedge clk);
        #1 e = q.pop_front();
        check(msel, e.sel);
        check(boe, e.oe);
        check(bdoe, e.doe);
        check(|msel && hit, 0);
      end
    end
  end

  initial begin
    #50us err_total++;
    $display("Error %0t: run did not complete", $time);
    finish_test;
  end

  initial begin
    cyc(10);
    rst <= 1'b0;
    hold_len(n);
    check(n, HOLD);
    @(posedge clk) pb <= 1'b0;
    cyc(3);
    #1 check(srst_n, 0);
    hold_len(n);
    check(n, HOLD);
    @(posedge clk) pb <= 1'b1;
    $display("reset one-shot done");
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      off <= m[1];
      rel <= m[0];
      cyc(4);
      for (int i = 0; i < 15; i++) acc(AD[i], i[0], i % 5 == 4);
      for (int i = 0; i < 20; i++)
        acc(16'($random(seed)), 1'($random(seed)), $random(seed) % 4 == 0);
      @(posedge clk) req_n <= 1'b1;
      gnt <= 1'b0;
      cyc(3);
    end
    $display("decode and release done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cut <= i[1:0];
      aux <= 4'($random(seed));
      so <= i[0];
      cyc(4);
      #1 check(xoe, 2'(~cut));
      check(xout, 0);
      check(auxo, aux);
      check(sol, so);
    end
    $display("straps and aux done");
    per(n);
    check(n, 2 * TS_HALF_CYC);
    @(posedge clk) xsel <= 1'b1;
    per(n);
    per(n);
    check(n, 100);
    $display("time states done");
    finish_test;
  end
endmodule
`default_nettype wire
